// ### rtl/ppbm_pkg.sv
package ppbm_pkg;
    // Machine cycle length in clocks
    localparam int unsigned MC_CLOCKS       = 4;
    // Stretch range of an external data move, in machine cycles
    localparam logic [3:0]  STRETCH_MIN     = 4'h2;
    localparam logic [3:0]  STRETCH_MAX     = 4'h9;
    // Internal code area top (32 KB) and internal data area top
    localparam logic [15:0] CODE_INT_TOP    = 16'h7FFF;
    localparam logic [15:0] XRAM_INT_TOP    = 16'h03FF;
    // Port latch reset value
    localparam logic [7:0]  LATCH_RST       = 8'hFF;
    localparam logic [3:0]  LATCH4_RST      = 4'hF;

    // Bus cycle kinds
    typedef enum logic [1:0] {
        PPBM_KIND_FETCH = 2'b00,
        PPBM_KIND_CODE  = 2'b01,
        PPBM_KIND_READ  = 2'b10,
        PPBM_KIND_WRITE = 2'b11
    } ppbm_kind_type;

    // Bus sequencer states
    typedef enum logic [2:0] {
        PPBM_IDLE  = 3'b000,
        PPBM_ADDR  = 3'b001,
        PPBM_DATA  = 3'b010,
        PPBM_HOLD  = 3'b011,
        PPBM_DONE  = 3'b100
    } ppbm_state_type;
endpackage

// ### rtl/ppbm_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two flip-flop synchroniser for all pin inputs
module ppbm_sync #(
    parameter int WIDTH = 36
) (
    input  wire logic             clock_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] pins_in,
    ppbm_sync_if.src              sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] stable_q;

    // First stage read only by the second stage
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q   <= '1;
            stable_q <= '1;
        end else begin
            meta_q   <= pins_in;
            stable_q <= meta_q;
        end
    end

    assign sync.level = stable_q;
endmodule
`default_nettype wire

// ### rtl/ppbm_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
// Synchronised pin levels passed from the synchroniser to the top
interface ppbm_sync_if #(parameter int WIDTH = 36);
    logic [WIDTH-1:0] level;
    modport src (output level);
    modport dst (input level);
endinterface
`default_nettype wire

// ### rtl/ppbm_top.sv
`timescale 1ns/1ps
`default_nettype none
module ppbm_top
    import ppbm_pkg::*;
(
    input  wire logic                  clock_in,
    input  wire logic                  rst_in,
    // Core request side
    input  wire logic                  req_valid_in,
    input  wire ppbm_pkg::ppbm_kind_type req_kind_in,
    input  wire logic [15:0]           req_addr_in,
    input  wire logic [7:0]            req_wdata_in,
    input  wire logic [3:0]            stretch_in,
    input  wire logic                  external_fetch_force_in,
    input  wire logic                  xram_enable_bit_in,
    input  wire logic                  wait_enable_in,
    output logic                       req_ready_out,
    output logic                       rsp_valid_out,
    output logic                       rsp_internal_out,
    output logic [7:0]                 rsp_rdata_out,
    // Port latches and alternate outputs from the core
    input  wire logic [7:0]            p0_latch_in,
    input  wire logic [7:0]            p1_latch_in,
    input  wire logic [7:0]            p2_latch_in,
    input  wire logic [7:0]            p3_latch_in,
    input  wire logic [3:0]            p4_latch_in,
    input  wire logic                  serial1_out_in,
    input  wire logic                  serial0_tx_in,
    // Pin levels
    input  wire logic [7:0]            p0_pin_in,
    input  wire logic [7:0]            p1_pin_in,
    input  wire logic [7:0]            p2_pin_in,
    input  wire logic [7:0]            p3_pin_in,
    input  wire logic [3:0]            p4_pin_in,
    // Pin drivers: data and active-low output enables
    output logic [7:0]                 p0_out,
    output logic [7:0]                 p0_oe_n_out,
    output logic [7:0]                 p1_out,
    output logic [7:0]                 p1_oe_n_out,
    output logic [7:0]                 p2_out,
    output logic [7:0]                 p2_oe_n_out,
    output logic [7:0]                 p3_out,
    output logic [7:0]                 p3_oe_n_out,
    output logic [3:0]                 p4_out,
    output logic [3:0]                 p4_oe_n_out,
    output logic                       addr_latch_strobe_out,
    output logic                       prog_fetch_strobe_n_out,
    // Synchronised alternate inputs to peripherals
    output logic                       timer2_count_in_out,
    output logic                       timer2_aux_ctl_in_out,
    output logic                       serial1_in_out,
    output logic [5:0]                 ext_irq_out,
    output logic                       serial0_rx_out,
    output logic                       timer0_ext_in_out,
    output logic                       timer1_ext_in_out,
    output logic                       wait_level_out,
    output logic [35:0]                pin_level_out
);
    import ppbm_pkg::*;

    // ==========================================================
    // Pin synchronisers
    ppbm_sync_if #(.WIDTH(36)) sync_bus ();
    logic [35:0] lvl;

    ppbm_sync #(.WIDTH(36)) u_sync (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .pins_in  ({p4_pin_in, p3_pin_in, p2_pin_in, p1_pin_in, p0_pin_in}),
        .sync     (sync_bus)
    );
    assign lvl = sync_bus.level;

    // Clamp a stretch request into the legal range
    function automatic logic [3:0] clamp_stretch(input logic [3:0] s);
        if (s < STRETCH_MIN) begin
            return STRETCH_MIN;
        end else if (s > STRETCH_MAX) begin
            return STRETCH_MAX;
        end
        return s;
    endfunction

    // ==========================================================
    // Machine cycle phase counter
    logic [1:0] phase_q;
    logic       mc_end;
    assign mc_end = (phase_q == 2'(MC_CLOCKS - 1));

    // Free-running four clock machine cycle
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    // ==========================================================
    // Bus sequencer
    ppbm_state_type state_q;
    ppbm_kind_type  kind_q;
    logic [15:0]    addr_q;
    logic [7:0]     wdata_q;
    logic [3:0]     mc_left_q;
    logic           on_chip;

    // Decide whether a request stays on chip
    always_comb begin
        case (req_kind_in)
            PPBM_KIND_FETCH, PPBM_KIND_CODE: begin
                on_chip = external_fetch_force_in &&
                          (req_addr_in <= CODE_INT_TOP);
            end
            default: begin
                on_chip = xram_enable_bit_in &&
                          (req_addr_in <= XRAM_INT_TOP);
            end
        endcase
    end

    // State machine, one step per machine cycle boundary
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_q   <= PPBM_IDLE;
            kind_q    <= PPBM_KIND_FETCH;
            addr_q    <= 16'h0000;
            wdata_q   <= 8'h00;
            mc_left_q <= 4'h0;
        end else if (mc_end) begin
            case (state_q)
                PPBM_IDLE: begin
                    if (req_valid_in && !on_chip) begin
                        state_q <= PPBM_ADDR;
                        kind_q  <= req_kind_in;
                        addr_q  <= req_addr_in;
                        wdata_q <= req_wdata_in;
                        if (req_kind_in[1]) begin
                            mc_left_q <= clamp_stretch(stretch_in) - 4'h2;
                        end else begin
                            mc_left_q <= 4'h0;
                        end
                    end
                end
                PPBM_ADDR: state_q <= PPBM_DATA;
                PPBM_DATA: begin
                    if (mc_left_q != 4'h0) begin
                        state_q <= PPBM_HOLD;
                    end else begin
                        state_q <= PPBM_DONE;
                    end
                end
                PPBM_HOLD: begin
                    if (kind_q[1] && wait_enable_in && !lvl[32]) begin
                        state_q <= PPBM_HOLD; // Wait pin low holds the cycle
                    end else if (mc_left_q <= 4'h1) begin
                        state_q   <= PPBM_DONE;
                        mc_left_q <= 4'h0;
                    end else begin
                        mc_left_q <= mc_left_q - 4'h1;
                    end
                end
                PPBM_DONE: state_q <= PPBM_IDLE;
                default:   state_q <= PPBM_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Request handshake and read data
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            req_ready_out    <= 1'b0;
            rsp_valid_out    <= 1'b0;
            rsp_internal_out <= 1'b0;
            rsp_rdata_out    <= 8'h00;
        end else begin
            req_ready_out    <= (state_q == PPBM_IDLE) && (phase_q == 2'(MC_CLOCKS - 2));
            rsp_valid_out    <= 1'b0;
            rsp_internal_out <= 1'b0;
            if (mc_end && state_q == PPBM_IDLE && req_valid_in && on_chip) begin
                rsp_valid_out    <= 1'b1;
                rsp_internal_out <= 1'b1;
            end
            if (mc_end && state_q == PPBM_DONE) begin
                rsp_valid_out <= 1'b1;
            end
            if (state_q == PPBM_DONE && phase_q == 2'h0 && kind_q != PPBM_KIND_WRITE) begin
                rsp_rdata_out <= lvl[7:0];
            end
        end
    end

    // ==========================================================
    // Pin drivers
    logic bus_on;
    logic data_phase;
    assign bus_on     = (state_q != PPBM_IDLE);
    assign data_phase = (state_q == PPBM_DATA) || (state_q == PPBM_HOLD) ||
                        (state_q == PPBM_DONE);

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            p0_out      <= LATCH_RST;
            p0_oe_n_out <= 8'hFF;
            p2_out      <= LATCH_RST;
            p2_oe_n_out <= 8'hFF;
        end else if (bus_on) begin
            p2_out      <= addr_q[15:8];
            p2_oe_n_out <= 8'h00;
            if (!data_phase) begin
                p0_out      <= addr_q[7:0];
                p0_oe_n_out <= 8'h00;
            end else if (kind_q == PPBM_KIND_WRITE) begin
                p0_out      <= wdata_q;
                p0_oe_n_out <= 8'h00;
            end else begin
                p0_out      <= 8'hFF;
                p0_oe_n_out <= 8'hFF; // Released for read data
            end
        end else begin
            p0_out      <= 8'h00;
            p0_oe_n_out <= p0_latch_in;
            p2_out      <= 8'h00;
            p2_oe_n_out <= p2_latch_in; // weak pull-up keeps ones
        end
    end

    // Port 1, 3 with alternate outputs, port 4 bit 0 released for the wait input
    logic [7:0] p3_val;
    always_comb begin
        p3_val    = p3_latch_in;
        p3_val[1] = p3_latch_in[1] & serial0_tx_in;
        if (bus_on && kind_q == PPBM_KIND_WRITE && data_phase) begin
            p3_val[6] = 1'b0;
        end
        if (bus_on && kind_q == PPBM_KIND_READ && data_phase) begin
            p3_val[7] = 1'b0;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            p1_out      <= 8'h00;
            p1_oe_n_out <= 8'hFF;
            p3_out      <= 8'h00;
            p3_oe_n_out <= 8'hFF;
            p4_out      <= 4'h0;
            p4_oe_n_out <= LATCH4_RST;
        end else begin
            p1_out      <= 8'h00;
            p1_oe_n_out <= {p1_latch_in[7:4], p1_latch_in[3] & serial1_out_in,
                            p1_latch_in[2:0]};
            p3_out      <= 8'h00;
            p3_oe_n_out <= p3_val;
            p4_out      <= 4'h0;
            p4_oe_n_out <= {p4_latch_in[3:1], p4_latch_in[0] | wait_enable_in};
        end
    end

    // ==========================================================
    // Strobes: latch pulse in address cycle, fetch strobe in data cycle
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            addr_latch_strobe_out   <= 1'b0;
            prog_fetch_strobe_n_out <= 1'b1;
        end else begin
            addr_latch_strobe_out   <= (state_q == PPBM_ADDR) && (phase_q <= 2'h1);
            prog_fetch_strobe_n_out <= !(data_phase && !kind_q[1]);
        end
    end

    // ==========================================================
    // Alternate input functions
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            timer2_count_in_out   <= 1'b1;
            timer2_aux_ctl_in_out <= 1'b1;
            serial1_in_out        <= 1'b1;
            ext_irq_out           <= 6'h3F;
            serial0_rx_out        <= 1'b1;
            timer0_ext_in_out     <= 1'b1;
            timer1_ext_in_out     <= 1'b1;
            wait_level_out        <= 1'b1;
            pin_level_out         <= '1;
        end else begin
            timer2_count_in_out   <= lvl[8];
            timer2_aux_ctl_in_out <= lvl[9];
            serial1_in_out        <= lvl[10];
            ext_irq_out           <= {lvl[15:12], lvl[27:26]};
            serial0_rx_out        <= lvl[24];
            timer0_ext_in_out     <= lvl[28];
            timer1_ext_in_out     <= lvl[29];
            wait_level_out        <= lvl[32] | !wait_enable_in;
            pin_level_out         <= lvl;
        end
    end

    // ==========================================================
    // Assertions
    p2_addr_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (state_q == PPBM_DATA) |=> (p2_out == addr_q[15:8] && p2_oe_n_out == 8'h00))
        else $error("port 2 not carrying high address");
    wait_pin_a: assert property (@(posedge clock_in) disable iff (rst_in)
        wait_enable_in |=> p4_oe_n_out[0])
        else $error("wait pin driven");
    mc_len_a: assert property (@(posedge clock_in) disable iff (rst_in)
        mc_end |=> !mc_end [*3] ##1 mc_end)
        else $error("machine cycle not four clocks");
    int_code_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (mc_end && state_q == PPBM_IDLE && req_valid_in && on_chip) |=>
        (state_q == PPBM_IDLE && rsp_internal_out))
        else $error("on-chip access went to bus");
    // Strobe high for two clocks while port 0 shows the low address
    sequence addr_latch_s;
        (state_q == PPBM_ADDR && p0_oe_n_out == 8'h00 && p0_out == addr_q[7:0]) ##1
        addr_latch_strobe_out ##1 !addr_latch_strobe_out;
    endsequence
    addr_latch_a: assert property (@(posedge clock_in) disable iff (rst_in)
        $rose(addr_latch_strobe_out) |-> addr_latch_s)
        else $error("latch strobe outside address cycle");
    stretch_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (mc_end && state_q == PPBM_IDLE) |=> (mc_left_q <= 4'h7))
        else $error("stretch out of range");
endmodule
`default_nettype wire

// ### verification/ppbm_ext_mem.sv
`timescale 1ns/1ps
`default_nettype none
// =========================
// External memory on the multiplexed bus
module ppbm_ext_mem (
    input  wire logic       clock_in,
    input  wire logic       ale_in,
    input  wire logic       fetch_n_in,
    input  wire logic       rd_n_in,
    input  wire logic       wr_n_in,
    input  wire logic [7:0] p0_in,
    input  wire logic [7:0] p2_in,
    input  wire logic [3:0] wait_cyc_in,
    output logic [7:0]      data_out,
    output logic            data_oe_n_out,
    output logic            wait_n_out,
    output logic [7:0]      last_wr_out,
    output logic [7:0]      rd_cnt_out,
    output logic [7:0]      wr_cnt_out
);
    logic [15:0] addr_q = 16'h0000;
    logic [7:0]  wd_q   = 8'h00;
    logic [7:0]  rc_q   = 8'h00;
    logic [7:0]  wc_q   = 8'h00;
    logic        rd_q   = 1'b1;
    logic        wr_q   = 1'b1;
    logic [3:0]  hold_q = 4'h0;
    // Low address taken off port 0 while the latch strobe is high
    always_ff @(posedge clock_in) begin
        if (ale_in) begin
            addr_q <= {p2_in, p0_in};
        end
    end
    // Strobe edges, write capture and wait stretching
    always_ff @(posedge clock_in) begin
        rd_q <= rd_n_in;
        wr_q <= wr_n_in;
        if (!wr_n_in) begin
            wd_q <= p0_in;
        end
        if (rd_q & ~rd_n_in) begin
            rc_q <= rc_q + 8'h01;
        end
        if (wr_q & ~wr_n_in) begin
            wc_q <= wc_q + 8'h01;
        end
        if ((rd_q & ~rd_n_in) | (wr_q & ~wr_n_in)) begin
            hold_q <= wait_cyc_in;
        end else if (hold_q != 4'h0) begin
            hold_q <= hold_q - 4'h1;
        end
    end
    // Read data follows the latched address; the bus is let go otherwise
    assign data_out      = addr_q[7:0] ^ addr_q[15:8] ^ 8'h3C;
    assign data_oe_n_out = rd_n_in & fetch_n_in;
    assign wait_n_out    = (hold_q == 4'h0);
    assign last_wr_out   = wd_q;
    assign rd_cnt_out    = rc_q;
    assign wr_cnt_out    = wc_q;
endmodule
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ppbm_pkg::*;
    logic clock_in = 1'b0;
    logic rst_in, req_v, eff, xen, wen, s1o, s0o, rdy, rsp_v, rsp_i, ale, psn, t2c, t2x, s1i;
    logic s0r, t0, t1, wlv, me_n, wt_n, got_i;
    ppbm_kind_type kind;
    logic [15:0] addr;
    logic [7:0]  wdat, l0, l1, l2, l3, x1, x3, rd, o0, e0, o1, e1, o2, e2, o3, e3, md;
    logic [7:0]  lw, rc, wc, got_r, a0, ae0, a2, ae2, pp0, pp1, pp2, pp3;
    logic [3:0]  str, l4, wcy, o4, e4, pp4;
    logic [5:0]  irq;
    logic [35:0] lvl;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          ale_cnt, prog_fetch_strobe_cnt;
    // ==========
    // Pin levels: weak pull-ups, external pulls, memory on port 0
    assign pp0 = me_n ? (o0 | e0) : md;
    assign pp1 = (o1 | e1) & x1;
    assign pp2 = o2 | e2;
    assign pp3 = (o3 | e3) & x3;
    assign pp4 = (o4 | e4) & {3'b111, wt_n};
    // Clock
    always #4 clock_in = ~clock_in;
    // Bus monitor
    always @(posedge clock_in) begin
        if (ale) begin
            ale_cnt++;
            {a0, ae0, a2, ae2} = {o0, e0, o2, e2};
        end
        if (!psn) prog_fetch_strobe_cnt++;
    end
    ppbm_top uut (.clock_in(clock_in), .rst_in(rst_in), .req_valid_in(req_v),
        .req_kind_in(kind), .req_addr_in(addr), .req_wdata_in(wdat), .stretch_in(str),
        .external_fetch_force_in(eff), .xram_enable_bit_in(xen), .wait_enable_in(wen),
        .req_ready_out(rdy), .rsp_valid_out(rsp_v), .rsp_internal_out(rsp_i),
        .rsp_rdata_out(rd), .p0_latch_in(l0), .p1_latch_in(l1), .p2_latch_in(l2),
        .p3_latch_in(l3), .p4_latch_in(l4), .serial1_out_in(s1o), .serial0_tx_in(s0o),
        .p0_pin_in(pp0), .p1_pin_in(pp1), .p2_pin_in(pp2), .p3_pin_in(pp3), .p4_pin_in(pp4),
        .p0_out(o0), .p0_oe_n_out(e0), .p1_out(o1), .p1_oe_n_out(e1), .p2_out(o2),
        .p2_oe_n_out(e2), .p3_out(o3), .p3_oe_n_out(e3), .p4_out(o4), .p4_oe_n_out(e4),
        .addr_latch_strobe_out(ale), .prog_fetch_strobe_n_out(psn),
        .timer2_count_in_out(t2c), .timer2_aux_ctl_in_out(t2x), .serial1_in_out(s1i),
        .ext_irq_out(irq), .serial0_rx_out(s0r), .timer0_ext_in_out(t0),
        .timer1_ext_in_out(t1), .wait_level_out(wlv), .pin_level_out(lvl));
    ppbm_ext_mem mem (.clock_in(clock_in), .ale_in(ale), .fetch_n_in(psn), .rd_n_in(pp3[7]),
        .wr_n_in(pp3[6]), .p0_in(pp0), .p2_in(pp2), .wait_cyc_in(wcy), .data_out(md),
        .data_oe_n_out(me_n), .wait_n_out(wt_n), .last_wr_out(lw), .rd_cnt_out(rc),
        .wr_cnt_out(wc));
    // ==========
    // Shared tasks
    task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim;
        if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One bus cycle; length counted in clocks from the first latch strobe
    task automatic bus(input ppbm_kind_type k, input logic [15:0] a, output int len);
        int n;
        logic rs;
        @(posedge clock_in);
        #1;
        {ale_cnt, prog_fetch_strobe_cnt, n, len} = 0;
        kind = k;
        {addr, wdat, req_v} = {a, a[7:0] ^ 8'hC3, 1'b1};
        rs = rdy;
        do begin
            @(posedge clock_in);
            #1;
            n++;
            if (ale_cnt > 0) len++;
            else rs = rs | rdy;
        end while (rsp_v !== 1'b1 && n < 300);
        chk("response", rsp_v, 1);
        chk("ready", rs, 1);
        {got_i, got_r, req_v} = {rsp_i, rd, 1'b0};
    endtask
    task automatic one_cyc(input ppbm_kind_type k, input logic [15:0] a, input logic e, x, ei);
        int len;
        logic [7:0] r0, w0;
        {eff, xen, r0, w0} = {e, x, rc, wc};
        bus(k, a, len);
        chk("internal", got_i, ei);
        if (ei) begin
            chk("quiet bus", {8'(rc - r0), 8'(wc - w0), 8'(ale_cnt), 8'(prog_fetch_strobe_cnt)}, 0);
        end else begin
            chk("addr low", {ae0, a0}, {8'h00, a[7:0]});
            chk("addr high", {ae2, a2}, {8'h00, a[15:8]});
            if (k == PPBM_KIND_WRITE) chk("write", {8'(wc - w0), lw}, {8'h01, a[7:0] ^ 8'hC3});
            else chk("read data", got_r, a[7:0] ^ a[15:8] ^ 8'h3C);
            if (k == PPBM_KIND_READ) chk("read strobe", 8'(rc - r0), 1);
            chk("fetch strobe", prog_fetch_strobe_cnt > 0, k < PPBM_KIND_READ);
        end
    endtask
    // ==========
    // Scenarios
    task automatic t_gpio;
        {l0, l1, l2, l3, l4, s1o, s0o} = {8'hA5, 8'h3C, 8'h96, 8'hF3, 4'h9, 2'b00};
        repeat (4) @(posedge clock_in);
        #1;
        chk("p0 high drive", o0 & ~e0, 0);
        chk("levels", {pp0, pp1, pp2, pp3, pp4}, {36'hA5_3496_F19});
        {l0, l1, l2, l3, l4, s1o, s0o} = {32'hFFFF_FFFF, 4'hF, 2'b11};
    endtask
    task automatic t_alt;
        logic [7:0] p;
        for (int i = 0; i < 2; i++) begin
            p = i ? 8'h5A : 8'hA5;
            {x1, x3} = {p, 2'b11, ~p[5:0]};
            repeat (6) @(posedge clock_in);
            #1;
            chk("port1 alt", {t2c, t2x, s1i, irq[5:2]}, {p[0], p[1], p[2], p[7:4]});
            chk("port3 alt", {s0r, irq[1:0], t0, t1}, {~p[0], ~p[3:2], ~p[4], ~p[5]});
            chk("pin levels", lvl, {pp4, pp3, pp2, pp1, pp0});
        end
        {x1, x3} = 16'hFFFF;
    endtask
    task automatic t_cycles;
        one_cyc(PPBM_KIND_FETCH, 16'h9234, 1, 0, 0);
        one_cyc(PPBM_KIND_FETCH, 16'h7FFF, 1, 0, 1);
        one_cyc(PPBM_KIND_FETCH, 16'h1234, 0, 0, 0);
        one_cyc(PPBM_KIND_CODE, 16'h8000, 1, 0, 0);
        one_cyc(PPBM_KIND_CODE, 16'h0100, 1, 0, 1);
        one_cyc(PPBM_KIND_READ, 16'h03FF, 1, 1, 1);
        one_cyc(PPBM_KIND_READ, 16'h0400, 1, 1, 0);
        one_cyc(PPBM_KIND_WRITE, 16'h0000, 1, 0, 0);
        one_cyc(PPBM_KIND_WRITE, 16'h03FF, 1, 1, 1);
    endtask
    task automatic t_stretch;
        int lens[11];
        int c;
        xen = 1'b0;
        for (int s = 0; s < 11; s++) begin
            str = 4'(s);
            bus(PPBM_KIND_READ, 16'h2000, lens[s]);
        end
        for (int s = 0; s < 11; s++) begin
            c = (s < STRETCH_MIN) ? STRETCH_MIN : ((s > STRETCH_MAX) ? STRETCH_MAX : s);
            chk("stretch", lens[s] - lens[2], MC_CLOCKS * (c - 2));
        end
    endtask
    task automatic t_wait;
        int n0, n1;
        {wen, l4, str, wcy} = {1'b1, 4'h0, 4'h3, 4'h0};
        repeat (4) @(posedge clock_in);
        chk("port4 enables", e4, 4'h1);
        bus(PPBM_KIND_READ, 16'h2000, n0);
        wcy = 4'h8;
        bus(PPBM_KIND_READ, 16'h2000, n1);
        chk("wait stretch", n1 > n0, 1);
        chk("wait level", wlv, 1);
        {wen, l4, wcy} = {1'b0, 4'hF, 4'h0};
    endtask
    // Main sequence
    initial begin
        rst_in = 1'b1;
        kind   = PPBM_KIND_FETCH;
        {req_v, addr, wdat, str, eff, xen, wen, s1o, s0o} = {1'b0, 24'h00_0000, 4'h2, 5'h13};
        {l0, l1, l2, l3, l4, x1, x3, wcy} = {32'hFFFF_FFFF, 4'hF, 16'hFFFF, 4'h0};
        repeat (4) @(posedge clock_in);
        #1;
        chk("reset enables", {e0, e1, e2, e3, e4, ale, psn}, {36'hF_FFFF_FFFF, 2'b01});
        rst_in = 1'b0;
        t_gpio;
        t_alt;
        t_cycles;
        t_stretch;
        t_wait;
        end_sim;
    end
    // Watchdog
    initial begin
        #(8 * 20000);
        n_mismatch++;
        end_sim;
    end
endmodule
`default_nettype wire
